//--- shared/dsau_pkg.sv
// Purpose: constants, types and map of the data space access unit
// Assumes: 16-bit byte-addressed data space, one core clock
// Notes  : Operation
// Operation
// - post-increment pointer steps one for byte, two for word accesses
// - byte read fetches whole word, address bit 0 picks byte, lands low
// - byte write strobes only the lane picked by the byte address
// - word read or write at odd address raises address error trap
// - misaligned read still completes its instruction before the trap
// - misaligned write executes but memory write is suppressed, then trap
// - byte load into a working register changes only its low byte
// - sign-extend turns low signed byte of a register into 16 bits
// - zero-extend clears the high byte of a working register
// - addresses 0x0000 to 0x07FF decode as special function registers
// - unused special function register addresses read as zero
// - memory direct access reaches 0x0000 to 0x1FFF with 13-bit field
// - move access reaches whole space by 16-bit field or pointer
// - two address generation units with separate paths, two words per cycle
// - X space has own read and write buses; X read serves all reads
// - multiply-accumulate class uses Y as concurrent second read path
// - modulo addressing in X and Y; bit-reversed only for X writes
// - all writes use unified X plus Y range; boundary fixed per device
// - effective addresses are 16-bit byte addresses over 64 Kbytes
// - 1 Kbyte dual-ported RAM at top of Y, CPU and DMA together
// - same-location write conflict between CPU and DMA goes to CPU
// - DMA access to dual-ported RAM never stalls the CPU
// - reads outside implemented memory return all zeros
// - addresses with bit 15 set are not implemented RAM; 0x9000 maps register 3
`default_nettype none
package dsau_pkg;
    localparam int DW        = 16;
    localparam int NUM_WREGS = 4;
    localparam int NEAR_W    = 13;
    localparam int PSV_BIT   = 15;
    localparam int BYTE_W    = 8;

    localparam logic [15:0] SFR_END = 16'h07FF;
    localparam logic [15:0] WREG_OFF [NUM_WREGS] = '{16'h0000, 16'h0000, 16'h0004, 16'h9000};
    localparam logic [15:0] WREG_RST [NUM_WREGS] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};

    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [1:0]  LANE_LO   = 2'h1;
    localparam logic [1:0]  LANE_HI   = 2'h2;
    localparam logic [1:0]  LANE_BOTH = 2'h3;

    localparam logic [15:0] GEN_BASE_DEF  = 16'h0800;
    localparam int          GEN_WORDS_DEF = 1536;
    localparam logic [15:0] Y_BASE_DEF    = 16'h0C00;
    localparam logic [15:0] DMA_BASE_DEF  = 16'h1400;
    localparam int          DMA_WORDS_DEF = 512;

    typedef enum logic [2:0] {
        OP_NOP, OP_LOAD, OP_STORE, OP_SIGN_EXT, OP_ZERO_EXT, OP_DUAL_READ
    } dsau_op_t;

    typedef enum logic [1:0] {
        AM_NEAR_DIRECT, AM_FULL_DIRECT, AM_INDIRECT, AM_POST_INC
    } dsau_mode_t;
endpackage : dsau_pkg
`default_nettype wire

//--- shared/dsau_ifs.sv
// Purpose: carriers between the access unit and its address and RAM blocks
// Assumes: all signals on the core clock
// Notes  : ctl is the access unit side
`default_nettype none
interface dsau_agu_if;
    import dsau_pkg::*;
    dsau_mode_t  mode;
    logic        byte_op;
    logic [15:0] direct;
    logic [15:0] ptr;
    logic        mod_en;
    logic [15:0] mod_start;
    logic [15:0] mod_end;
    logic        brev_en;
    logic [15:0] brev_mod;
    logic [15:0] ea;
    logic [15:0] ptr_next;
    logic        ptr_upd;
    modport agu (input mode, byte_op, direct, ptr, mod_en, mod_start, mod_end,
                 brev_en, brev_mod, output ea, ptr_next, ptr_upd);
    modport ctl (output mode, byte_op, direct, ptr, mod_en, mod_start, mod_end,
                 brev_en, brev_mod, input ea, ptr_next, ptr_upd);
endinterface : dsau_agu_if

interface dsau_ram_if #(parameter int AW = 9);
    logic          cpu_we;
    logic [1:0]    cpu_be;
    logic [AW-1:0] cpu_idx;
    logic [15:0]   cpu_wdata;
    logic [AW-1:0] x_idx;
    logic [AW-1:0] y_idx;
    logic [15:0]   x_rdata;
    logic [15:0]   y_rdata;
    modport ram (input cpu_we, cpu_be, cpu_idx, cpu_wdata, x_idx, y_idx,
                 output x_rdata, y_rdata);
    modport ctl (output cpu_we, cpu_be, cpu_idx, cpu_wdata, x_idx, y_idx,
                 input x_rdata, y_rdata);
endinterface : dsau_ram_if
`default_nettype wire

//--- core/dsau_agu.sv
// Purpose: effective address and pointer update for one address path
// Assumes: purely combinational, used once for X and once for Y
// Notes  : bit reverse wins over modulo when both are asked for
`default_nettype none
module dsau_agu
    import dsau_pkg::*;
(
    dsau_agu_if.agu a
);
    logic [15:0] step;
    logic [15:0] inc;
    logic [15:0] rsum;

    function automatic logic [15:0] dsau_rev(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < DW; i++) r[i] = v[DW-1-i];
        return r;
    endfunction : dsau_rev

    // address source by mode; near form zero-extends the short field
    always_comb begin
        unique case (a.mode)
            AM_NEAR_DIRECT: a.ea = {{(DW-NEAR_W){1'b0}}, a.direct[NEAR_W-1:0]};
            AM_FULL_DIRECT: a.ea = a.direct;
            AM_INDIRECT:    a.ea = a.ptr;
            AM_POST_INC:    a.ea = a.ptr;
        endcase
    end

    // step scales with access size so word steps keep an even pointer even
    assign step       = a.byte_op ? STEP_BYTE : STEP_WORD;
    assign inc        = a.ptr + step;
    // reverse-carry add: carries ripple from the top bit downward
    assign rsum       = dsau_rev(dsau_rev(a.ptr) + dsau_rev(a.brev_mod));
    assign a.ptr_upd  = (a.mode == AM_POST_INC);
    assign a.ptr_next = a.brev_en ? rsum :
                        (a.mod_en && inc > a.mod_end) ? a.mod_start : inc;
endmodule : dsau_agu
`default_nettype wire

//--- core/dsau_dpram.sv
// Purpose: dual-ported RAM shared by the CPU paths and the DMA master
// Assumes: DMA port always accepted, read data one cycle after request
// Notes  : no arbitration stall exists, so a DMA burst costs the CPU nothing
`default_nettype none
module dsau_dpram
    import dsau_pkg::*;
#(
    parameter int WORDS = DMA_WORDS_DEF,
    parameter int AW    = $clog2(DMA_WORDS_DEF)
) (
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    dsau_ram_if.ram            cpu,
    input  wire logic          dma_req_in,
    input  wire logic          dma_we_in,
    input  wire logic [1:0]    dma_be_in,
    input  wire logic [AW-1:0] dma_index_in,
    input  wire logic [15:0]   dma_wdata_in,
    output logic      [15:0]   dma_rdata_out
);
    logic [15:0] mem [WORDS];

    // both CPU read paths see the array directly
    assign cpu.x_rdata = mem[cpu.x_idx];
    assign cpu.y_rdata = mem[cpu.y_idx];

    // DMA lanes are written first so a CPU lane to the same word overrides
    always_ff @(posedge clk_in) begin
        for (int b = 0; b < 2; b++) begin
            if (dma_req_in && dma_we_in && dma_be_in[b])
                mem[dma_index_in][b*BYTE_W +: BYTE_W] <= dma_wdata_in[b*BYTE_W +: BYTE_W];
            if (cpu.cpu_we && cpu.cpu_be[b])
                mem[cpu.cpu_idx][b*BYTE_W +: BYTE_W] <= cpu.cpu_wdata[b*BYTE_W +: BYTE_W];
        end
    end

    // DMA read data is registered and never waits on the CPU
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dma_rdata_out <= 16'h0000;
        end else if (dma_req_in && !dma_we_in) begin
            dma_rdata_out <= mem[dma_index_in];
        end
    end
endmodule : dsau_dpram
`default_nettype wire

//--- core/dsau_top.sv
// Purpose: data space access unit: address decode, byte lanes, X and Y reads
// Assumes: one operation per cycle on op_valid_in, inputs on clk_in
// Notes  : results and trap appear one edge after the operation is taken
`default_nettype none
module dsau_top
    import dsau_pkg::*;
#(
    parameter logic [15:0] GEN_BASE  = GEN_BASE_DEF,
    parameter int          GEN_WORDS = GEN_WORDS_DEF,
    parameter logic [15:0] Y_BASE    = Y_BASE_DEF,
    parameter logic [15:0] DMA_BASE  = DMA_BASE_DEF,
    parameter int          DMA_WORDS = DMA_WORDS_DEF
) (
    input  wire logic                           clk_in,
    input  wire logic                           rst_in,
    input  wire logic                           op_valid_in,
    input  wire dsau_op_t                       op_in,
    input  wire logic                           byte_op_in,
    input  wire dsau_mode_t                     x_mode_in,
    input  wire logic [15:0]                    x_direct_in,
    input  wire logic [1:0]                     x_ptr_sel_in,
    input  wire logic [1:0]                     reg_sel_in,
    input  wire logic [1:0]                     y_ptr_sel_in,
    input  wire logic                           y_post_inc_in,
    input  wire logic                           mod_en_in,
    input  wire logic [15:0]                    mod_start_in,
    input  wire logic [15:0]                    mod_end_in,
    input  wire logic                           brev_en_in,
    input  wire logic [15:0]                    brev_mod_in,
    input  wire logic                           dma_req_in,
    input  wire logic                           dma_we_in,
    input  wire logic [1:0]                     dma_be_in,
    input  wire logic [$clog2(DMA_WORDS)-1:0]   dma_index_in,
    input  wire logic [15:0]                    dma_wdata_in,
    output logic      [15:0]                    x_rdata_out,
    output logic      [15:0]                    y_rdata_out,
    output logic      [15:0]                    x_ea_out,
    output logic                                addr_err_trap_out,
    output logic      [15:0]                    dma_rdata_out,
    output logic      [NUM_WREGS-1:0][15:0]     working_regs_out
);
    localparam int GEN_AW = $clog2(GEN_WORDS);
    localparam int DMA_AW = $clog2(DMA_WORDS);
    localparam logic [16:0] GEN_END = {1'b0, GEN_BASE} + 17'(2 * GEN_WORDS);
    localparam logic [16:0] DMA_END = {1'b0, DMA_BASE} + 17'(2 * DMA_WORDS);

    logic [NUM_WREGS-1:0][15:0] wreg_reg;
    logic [NUM_WREGS-1:0][15:0] wreg_next;
    logic [15:0]                gen_mem [GEN_WORDS];
    logic [15:0]                x_rdata_reg;
    logic [15:0]                y_rdata_reg;
    logic [15:0]                x_ea_reg;
    logic                       trap_reg;

    dsau_agu_if x_if ();
    dsau_agu_if y_if ();
    dsau_ram_if #(.AW(DMA_AW)) r_if ();

    // two independent address units, one per read path
    dsau_agu u_x_agu (.a(x_if.agu));
    dsau_agu u_y_agu (.a(y_if.agu));

    dsau_dpram #(
        .WORDS (DMA_WORDS),
        .AW    (DMA_AW)
    ) u_dpram (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .cpu           (r_if.ram),
        .dma_req_in    (dma_req_in),
        .dma_we_in     (dma_we_in),
        .dma_be_in     (dma_be_in),
        .dma_index_in  (dma_index_in),
        .dma_wdata_in  (dma_wdata_in),
        .dma_rdata_out (dma_rdata_out)
    );

    // operation class decode
    wire is_load  = op_valid_in && (op_in == OP_LOAD);
    wire is_store = op_valid_in && (op_in == OP_STORE);
    wire is_dual  = op_valid_in && (op_in == OP_DUAL_READ);
    wire is_sext  = op_valid_in && (op_in == OP_SIGN_EXT);
    wire is_zext  = op_valid_in && (op_in == OP_ZERO_EXT);
    wire x_used   = is_load || is_store || is_dual;
    // dual-operand reads are always words
    wire x_byte   = byte_op_in && !is_dual;

    // X address unit; bit reverse only allowed on an X write
    assign x_if.mode      = x_mode_in;
    assign x_if.byte_op   = x_byte;
    assign x_if.direct    = x_direct_in;
    assign x_if.ptr       = wreg_reg[x_ptr_sel_in];
    assign x_if.mod_en    = mod_en_in;
    assign x_if.mod_start = mod_start_in;
    assign x_if.mod_end   = mod_end_in;
    assign x_if.brev_en   = brev_en_in && is_store;
    assign x_if.brev_mod  = brev_mod_in;

    // Y address unit: pointer modes only, never bit reversed
    assign y_if.mode      = y_post_inc_in ? AM_POST_INC : AM_INDIRECT;
    assign y_if.byte_op   = 1'b0;
    assign y_if.direct    = 16'h0000;
    assign y_if.ptr       = wreg_reg[y_ptr_sel_in];
    assign y_if.mod_en    = mod_en_in;
    assign y_if.mod_start = mod_start_in;
    assign y_if.mod_end   = mod_end_in;
    assign y_if.brev_en   = 1'b0;
    assign y_if.brev_mod  = brev_mod_in;

    wire [15:0] x_ea = x_if.ea;
    wire [15:0] y_ea = y_if.ea;

    // word index into the shared RAM for each path
    wire [15:0] x_dma_off = x_ea - DMA_BASE;
    wire [15:0] y_dma_off = y_ea - DMA_BASE;
    assign r_if.x_idx = x_dma_off[DMA_AW:1];
    assign r_if.y_idx = y_dma_off[DMA_AW:1];

    // one decode serves both read paths; anything unmapped reads zero
    function automatic logic [15:0] dsau_rd_word(input logic [15:0] ea,
                                                 input logic [15:0] dma_w);
        logic [15:0]       go;
        logic [GEN_AW-1:0] gi;
        logic              hit;
        go = ea - GEN_BASE;
        gi = go[GEN_AW:1];
        hit = 1'b0;
        dsau_rd_word = 16'h0000;
        // descending scan so the lowest register wins a shared offset
        for (int i = NUM_WREGS - 1; i >= 0; i--) begin
            if (ea[15:1] == WREG_OFF[i][15:1]) begin
                dsau_rd_word = wreg_reg[i];
                hit = 1'b1;
            end
        end
        if (!hit) begin
            if (ea[PSV_BIT]) begin
                dsau_rd_word = 16'h0000;
            end else if (ea <= SFR_END) begin
                dsau_rd_word = 16'h0000;
            end else if ({1'b0, ea} >= {1'b0, GEN_BASE} && {1'b0, ea} < GEN_END) begin
                dsau_rd_word = gen_mem[gi];
            end else if ({1'b0, ea} >= {1'b0, DMA_BASE} && {1'b0, ea} < DMA_END) begin
                dsau_rd_word = dma_w;
            end
        end
    endfunction : dsau_rd_word

    // X read: whole word fetched, byte picked by address bit 0
    wire [15:0] x_word   = dsau_rd_word(x_ea, r_if.x_rdata);
    wire [7:0]  x_bsel   = x_ea[0] ? x_word[15:8] : x_word[7:0];
    wire [15:0] x_rd_val = x_byte ? {8'h00, x_bsel} : x_word;

    // Y read only answers inside Y space, concurrent with X
    wire        y_in_sp  = ({1'b0, y_ea} >= {1'b0, Y_BASE}) && !y_ea[PSV_BIT];
    wire [15:0] y_word   = dsau_rd_word(y_ea, r_if.y_rdata);
    wire [15:0] y_rd_val = y_in_sp ? y_word : 16'h0000;

    // word access to an odd byte address is misaligned
    wire mis_x = x_used && !x_byte && x_ea[0];
    wire mis_y = is_dual && y_ea[0];

    // write path: a misaligned store still runs but never reaches memory
    wire        wr_ok   = is_store && !mis_x;
    wire [1:0]  wr_be   = !x_byte ? LANE_BOTH : (x_ea[0] ? LANE_HI : LANE_LO);
    wire [15:0] src_w   = wreg_reg[reg_sel_in];
    wire [15:0] wr_data = x_byte ? {src_w[7:0], src_w[7:0]} : src_w;
    wire [15:0] gen_off = x_ea - GEN_BASE;
    wire [GEN_AW-1:0] gen_idx = gen_off[GEN_AW:1];
    wire        x_psv   = x_ea[PSV_BIT];
    // writes decode the unified space; Y boundary plays no part here
    wire in_gen = !x_psv && ({1'b0, x_ea} >= {1'b0, GEN_BASE}) && ({1'b0, x_ea} < GEN_END);
    wire in_dma = !x_psv && ({1'b0, x_ea} >= {1'b0, DMA_BASE}) && ({1'b0, x_ea} < DMA_END);

    assign r_if.cpu_we    = wr_ok && in_dma;
    assign r_if.cpu_be    = wr_be;
    assign r_if.cpu_idx   = x_dma_off[DMA_AW:1];
    assign r_if.cpu_wdata = wr_data;

    // register hits for a store, lowest index taking a shared offset
    logic [NUM_WREGS-1:0] wr_hit;
    always_comb begin
        wr_hit = '0;
        for (int i = NUM_WREGS - 1; i >= 0; i--) begin
            if (wr_ok && x_ea[15:1] == WREG_OFF[i][15:1]) begin
                wr_hit    = '0;
                wr_hit[i] = 1'b1;
            end
        end
    end

    // pointer updates proceed even when the access itself faults
    wire x_step = x_used && x_if.ptr_upd;
    wire y_step = is_dual && y_if.ptr_upd;

    // working register next value; a load or extend beats a pointer step
    always_comb begin
        for (int i = 0; i < NUM_WREGS; i++) begin
            wreg_next[i] = wreg_reg[i];
            if (x_step && x_ptr_sel_in == 2'(i))
                wreg_next[i] = x_if.ptr_next;
            if (y_step && y_ptr_sel_in == 2'(i))
                wreg_next[i] = y_if.ptr_next;
            if (wr_hit[i] && wr_be[0])
                wreg_next[i][7:0] = wr_data[7:0];
            if (wr_hit[i] && wr_be[1])
                wreg_next[i][15:8] = wr_data[15:8];
            if (reg_sel_in == 2'(i)) begin
                if (is_load && x_byte)
                    wreg_next[i] = {wreg_reg[i][15:8], x_rd_val[7:0]};
                else if (is_load)
                    wreg_next[i] = x_rd_val;
                else if (is_sext)
                    wreg_next[i] = {{BYTE_W{wreg_reg[i][7]}}, wreg_reg[i][7:0]};
                else if (is_zext)
                    wreg_next[i] = {8'h00, wreg_reg[i][7:0]};
            end
        end
    end

    // working registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < NUM_WREGS; i++) wreg_reg[i] <= WREG_RST[i];
        end else begin
            wreg_reg <= wreg_next;
        end
    end

    // general RAM lanes; no reset so the array stays plain storage
    always_ff @(posedge clk_in) begin
        if (wr_ok && in_gen && wr_be[0])
            gen_mem[gen_idx][7:0] <= wr_data[7:0];
        if (wr_ok && in_gen && wr_be[1])
            gen_mem[gen_idx][15:8] <= wr_data[15:8];
    end

    // read results, captured address and the one-cycle trap request
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            x_rdata_reg <= 16'h0000;
            y_rdata_reg <= 16'h0000;
            x_ea_reg    <= 16'h0000;
            trap_reg    <= 1'b0;
        end else begin
            trap_reg <= op_valid_in && (mis_x || mis_y);
            if (is_load || is_dual)
                x_rdata_reg <= x_rd_val;
            if (is_dual)
                y_rdata_reg <= y_rd_val;
            if (x_used)
                x_ea_reg <= x_ea;
        end
    end

    assign x_rdata_out       = x_rdata_reg;
    assign y_rdata_out       = y_rdata_reg;
    assign x_ea_out          = x_ea_reg;
    assign addr_err_trap_out = trap_reg;
    assign working_regs_out  = wreg_reg;
endmodule : dsau_top
`default_nettype wire

//--- testbench/dsau_properties.sv
// Purpose: port checks of the access unit
// Assumes: one clock, async high reset
// Notes  : results judged one edge later
`default_nettype none
module dsau_properties
    import dsau_pkg::*;
(
    input wire logic             clk_in,
    input wire logic             rst_in,
    input wire logic             op_valid_in,
    input wire dsau_op_t         op_in,
    input wire logic             byte_op_in,
    input wire dsau_mode_t       x_mode_in,
    input wire logic [15:0]      x_direct_in,
    input wire logic [1:0]       x_ptr_sel_in,
    input wire logic [1:0]       reg_sel_in,
    input wire logic             mod_en_in,
    input wire logic [15:0]      x_rdata_out,
    input wire logic [15:0]      x_ea_out,
    input wire logic             addr_err_trap_out,
    input wire logic [3:0][15:0] working_regs_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // register views at the cycle an op is offered
    wire [15:0] dst_w = working_regs_out[reg_sel_in];
    wire [7:0]  dhi_w = dst_w[15:8];
    wire [15:0] sx_w  = {{8{dst_w[7]}}, dst_w[7:0]};
    wire [15:0] inc_w = working_regs_out[x_ptr_sel_in] + (byte_op_in ? 16'h0001 : 16'h0002);
    wire        ld_w  = op_valid_in && op_in == OP_LOAD;
    wire        ls_w  = op_valid_in && op_in inside {OP_LOAD, OP_STORE};
    wire        dir_w = ld_w && x_mode_in == AM_FULL_DIRECT && !byte_op_in;
    // holes: no register, no ram
    wire        hole_w = !(x_direct_in[15:1] inside {15'h0000, 15'h0002, 15'h4800})
                         && (x_direct_in <= 16'h07FF || x_direct_in >= 16'h1800);

    a_trap_no_cause: assert property (!op_valid_in |=> !addr_err_trap_out)
        else $error("stray trap");
    a_trap_odd_word: assert property (ls_w && !byte_op_in && x_direct_in[0]
        && x_mode_in inside {AM_NEAR_DIRECT, AM_FULL_DIRECT} |=> addr_err_trap_out)
        else $error("no trap");
    a_byte_no_trap: assert property (ls_w && byte_op_in |=> !addr_err_trap_out)
        else $error("byte trap");
    a_ea_full_field: assert property (ld_w && x_mode_in == AM_FULL_DIRECT
        |=> x_ea_out == $past(x_direct_in))
        else $error("full ea");
    a_ea_near_field: assert property (ld_w && x_mode_in == AM_NEAR_DIRECT
        |=> x_ea_out == ($past(x_direct_in) & 16'h1FFF))
        else $error("near ea");
    a_byte_load_lanes: assert property (ld_w && byte_op_in
        |=> x_rdata_out[15:8] == 8'h00 && working_regs_out[$past(reg_sel_in)][15:8] == $past(dhi_w))
        else $error("byte load");
    a_sign_extend: assert property (op_valid_in && op_in == OP_SIGN_EXT
        |=> working_regs_out[$past(reg_sel_in)] == $past(sx_w))
        else $error("sign ext");
    a_zero_extend: assert property (op_valid_in && op_in == OP_ZERO_EXT
        |=> working_regs_out[$past(reg_sel_in)] == ($past(dst_w) & 16'h00FF))
        else $error("zero ext");
    a_post_inc_step: assert property (ld_w && x_mode_in == AM_POST_INC && !mod_en_in
        && reg_sel_in != x_ptr_sel_in |=> working_regs_out[$past(x_ptr_sel_in)] == $past(inc_w))
        else $error("ptr step");
    a_hole_reads_zero: assert property (dir_w && hole_w |=> x_rdata_out == 16'h0000)
        else $error("hole read");
endmodule : dsau_properties
`default_nettype wire

//--- testbench/dsau_dma_model.sv
// Purpose: dma master on the shared ram port
// Assumes: requests start after a rising edge
// Notes  : released index and data lines flip to catch stale use
`default_nettype none
module dsau_dma_model (
    input  wire logic        clk_in,
    input  wire logic [15:0] rdata_in,
    output logic             req_out,
    output logic             we_out,
    output logic [1:0]       be_out,
    output logic [8:0]       index_out,
    output logic [15:0]      wdata_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle lines at time zero
    initial begin
        {req_out, we_out, be_out, index_out, wdata_out} = '0;
    end
    // one taken edge, then one idle cycle
    task automatic xfer(logic w, logic [8:0] i, logic [15:0] v, logic [1:0] b);
        {req_out, we_out, be_out, index_out, wdata_out} = {1'b1, w, b, i, v};
        @(posedge clk_in) #1;
        req_out   = 1'b0;
        index_out = ~index_out;
        wdata_out = ~wdata_out;
        @(posedge clk_in) #1;
    endtask : xfer
endmodule : dsau_dma_model
`default_nettype wire

//--- testbench/tb_top.sv
// Purpose: bench for the access unit
// Assumes: one idle cycle after each op
// Notes  : ram seeded through the dma port
`default_nettype none
module tb_top;
    import dsau_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] SEED [4] = '{16'h80F3, 16'h0800, 16'h0C00, 16'h5AA5};
    logic clk_in, rst_in, op_valid_in, byte_op_in, y_post_inc_in, mod_en_in, brev_en_in;
    logic trap_seen, dma_req_in, dma_we_in, addr_err_trap_out;
    dsau_op_t         op_in;
    dsau_mode_t       x_mode_in;
    logic [15:0]      x_direct_in, mod_start_in, mod_end_in, brev_mod_in;
    logic [15:0]      x_rdata_out, y_rdata_out, x_ea_out, dma_rdata_out, dma_wdata_in;
    logic [1:0]       x_ptr_sel_in, reg_sel_in, y_ptr_sel_in, dma_be_in;
    logic [8:0]       dma_index_in;
    logic [3:0][15:0] working_regs_out;
    int               errors, n_compared, cycles;

    dsau_top dsau_top_inst (.*);
    dsau_dma_model dsau_dma_model_inst (.clk_in(clk_in), .rdata_in(dma_rdata_out),
        .req_out(dma_req_in), .we_out(dma_we_in), .be_out(dma_be_in),
        .index_out(dma_index_in), .wdata_out(dma_wdata_in));

    // 100 MHz core clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // hang guard; run needs under 300 cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            end_sim();
        end
    end

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // one op; trap caught in its only cycle
    task automatic op(dsau_op_t o, logic b, dsau_mode_t m, logic [15:0] a, logic [1:0] r);
        {op_valid_in, byte_op_in, x_direct_in, reg_sel_in} = {1'b1, b, a, r};
        op_in       = o;
        x_mode_in   = m;
        @(posedge clk_in) #1;
        trap_seen   = addr_err_trap_out;
        op_valid_in = 1'b0;
        @(posedge clk_in) #1;
    endtask : op
    task automatic ld(logic [15:0] a, logic b, logic [1:0] r);
        op(OP_LOAD, b, AM_FULL_DIRECT, a, r);
    endtask : ld
    task automatic st(logic [15:0] a, logic b, logic [1:0] r);
        op(OP_STORE, b, AM_FULL_DIRECT, a, r);
    endtask : st

    // main sequence
    initial begin
        {op_valid_in, byte_op_in, mod_en_in, brev_en_in, reg_sel_in} = 6'h00;
        op_in     = OP_NOP;
        x_mode_in = AM_NEAR_DIRECT;
        {x_direct_in, mod_start_in, mod_end_in, brev_mod_in} = '0;
        // x pointer 2, y pointer 1, y post-increment, reset held
        {x_ptr_sel_in, y_ptr_sel_in, y_post_inc_in, rst_in} = 6'h27;
        repeat (10) @(posedge clk_in);
        #1 rst_in = 1'b0;
        for (int i = 0; i < NUM_WREGS; i++) chk("reset reg", working_regs_out[i], WREG_RST[i]);
        for (int i = 0; i < 4; i++) dsau_dma_model_inst.xfer(1'b1, 9'(i), SEED[i], 2'h3);
        ld(16'h1400, 1'b0, 2'h1);
        chk("dma ram load", working_regs_out[1], 16'h80F3);
        ld(16'h1402, 1'b0, 2'h2);
        ld(16'h1406, 1'b0, 2'h3);
        st(16'h0800, 1'b0, 2'h1);
        st(16'h0801, 1'b1, 2'h3);
        ld(16'h0800, 1'b0, 2'h0);
        chk("byte lane store", x_rdata_out, 16'hA5F3);
        ld(16'h0801, 1'b1, 2'h1);
        chk("byte read", x_rdata_out, 16'h00A5);
        chk("byte load reg", working_regs_out[1], 16'h80A5);
        st(16'h0801, 1'b0, 2'h3);
        chk("odd store trap", 16'(trap_seen), 16'h0001);
        ld(16'h0800, 1'b0, 2'h0);
        chk("odd store kept", x_rdata_out, 16'hA5F3);
        ld(16'h0801, 1'b0, 2'h2);
        chk("odd load trap", 16'(trap_seen), 16'h0001);
        chk("odd load done", working_regs_out[2], 16'hA5F3);
        op(OP_LOAD, 1'b0, AM_NEAR_DIRECT, 16'hE800, 2'h0);
        chk("near ea", x_ea_out, 16'h0800);
        foreach (SEED[i]) begin
            ld(i == 0 ? 16'h0010 : (i == 1 ? 16'h2000 : 16'hA000), 1'b0, 2'h0);
            chk("hole read", x_rdata_out, 16'h0000);
        end
        st(16'h9000, 1'b0, 2'h1);
        chk("reg3 mapped", working_regs_out[3], 16'h80A5);
        op(OP_SIGN_EXT, 1'b0, AM_FULL_DIRECT, 16'h0000, 2'h1);
        chk("sign ext", working_regs_out[1], 16'hFFA5);
        op(OP_ZERO_EXT, 1'b0, AM_FULL_DIRECT, 16'h0000, 2'h3);
        chk("zero ext", working_regs_out[3], 16'h00A5);
        ld(16'h1402, 1'b0, 2'h2);
        op(OP_LOAD, 1'b1, AM_POST_INC, 16'h0000, 2'h0);
        chk("byte step", working_regs_out[2], 16'h0801);
        op(OP_LOAD, 1'b0, AM_POST_INC, 16'h0000, 2'h0);
        chk("odd ptr trap", 16'(trap_seen), 16'h0001);
        st(16'h0C00, 1'b0, 2'h3);
        ld(16'h1402, 1'b0, 2'h2);
        ld(16'h1404, 1'b0, 2'h1);
        op(OP_DUAL_READ, 1'b0, AM_POST_INC, 16'h0000, 2'h0);
        chk("x path", x_rdata_out, 16'hA5F3);
        chk("y path", y_rdata_out, 16'h00A5);
        chk("x word step", working_regs_out[2], 16'h0802);
        chk("y word step", working_regs_out[1], 16'h0C02);
        fork
            st(16'h140A, 1'b0, 2'h3);
            dsau_dma_model_inst.xfer(1'b1, 9'h005, 16'hBEEF, 2'h3);
        join
        dsau_dma_model_inst.xfer(1'b0, 9'h005, 16'h0000, 2'h3);
        chk("clash", dma_rdata_out, 16'h00A5);
        {mod_en_in, mod_end_in, mod_start_in} = {1'b1, 16'h0802, 16'h0800};
        op(OP_LOAD, 1'b0, AM_POST_INC, 16'h0000, 2'h0);
        chk("mod", working_regs_out[2], 16'h0800);
        {brev_en_in, brev_mod_in} = {1'b1, 16'h0800};
        op(OP_STORE, 1'b0, AM_POST_INC, 16'h0000, 2'h3);
        chk("brev", working_regs_out[2], 16'h0400);
        end_sim();
    end
endmodule : tb_top

bind dsau_top dsau_properties dsau_properties_inst (.*);
`default_nettype wire
